// file: verilog/npec_consts.svh
// Offsets, field positions, reset values and sizes of the page ECC checker.
// Assumes a 32-bit AXI4-Lite address space with byte addresses.
`ifndef NPEC_CONSTS_SVH
`define NPEC_CONSTS_SVH

`define NPEC_CTRL_ADDR 32'hFFFFE800
`define NPEC_STAT_LO_ADDR 32'hFFFFE808
`define NPEC_STAT_HI_ADDR 32'hFFFFE80C
`define NPEC_PR0_ADDR 32'hFFFFE810
`define NPEC_PR8_ADDR 32'hFFFFE830
`define NPEC_PR13_ADDR 32'hFFFFE844
`define NPEC_SECTORS 16
`define NPEC_SEC_BITS 4
`define NPEC_LOC_BITS 11
`define NPEC_LOC_LSB 0
`define NPEC_NPAR_LSB 12
`define NPEC_CODE_BITS 24
`define NPEC_LOC_ALL_ONES 11'h7FF
`define NPEC_CTRL_RESET 32'h00000000
`define NPEC_GRAN_BIT 0
`define NPEC_FLAG_REC 0
`define NPEC_FLAG_ECC 1
`define NPEC_FLAG_MUL 2
`define NPEC_RESP_OKAY 2'h0
`define NPEC_RESP_SLVERR 2'h2

`endif

// file: verilog/npec_pkg.sv
// Types shared by the page ECC checker and its bench.
// Assumes the constants header is compiled alongside.
package npec_pkg;

	// One byte on the flash data path
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] data;
	} npec_byte_t;

	// Stored code of one sector, fetched back from the spare area
	typedef struct packed {
		logic valid;
		logic [3:0] sector;
		logic [23:0] code;
	} npec_code_t;

	// Per-sector result flags
	typedef struct packed {
		logic mul;
		logic ecc;
		logic rec;
	} npec_flags_t;

	// Outcome of one code comparison
	typedef enum logic [1:0] {
		NPEC_CLEAN = 2'b00,
		NPEC_DATA_ONE = 2'b01,
		NPEC_CODE_ONE = 2'b10,
		NPEC_MULTI = 2'b11
	} npec_verdict_t;

endpackage

// file: verilog/npec_top.sv
// Page ECC checker: per-sector parity over a 4096-byte NAND page, error
// flags and single-error location, read by software over AXI4-Lite.
// Assumes the memory controller feeds page bytes and, on a read, the
// stored code of each sector after that sector's data.
//
// What this block does
// [R1] With correction granularity at zero all sector flags stay zero.
// [R2] Recoverable set with multi-fault clear means one correctable error.
// [R3] Recoverable set with multi-fault set means several uncorrectable errors.
// [R4] The parity-byte flag rises when exactly one bit of the stored code is wrong.
// [R5] For a parity-byte error the low 24 bits of the parity register show a one there.
// [R6] The multiple-error flag rises only when more than one error is found.
// [R7] After a single error the register shows the bad bit offset in the byte.
// [R8] After a single error the register shows the bad byte address in the sector.
// [R9] With several errors the offset and address fields carry no meaning.
// [R10] Software copies the parity registers into the spare area after a write.
// [R11] Flag set fifteen covers page bytes 3840 to 4095, one sector per index.
// [R12] Parity register eight covers page bytes 2048 to 2303.
// [R13] Parity register thirteen covers page bytes 3328 to 3583.
// [R14] Parity builds during write and read; results update at read completion.
// [R15] Each parity register also shows the inverse parity, or the error bit after a stored-code error there; unused bits read zero.
//
// Added by the designer: the AXI4-Lite register port.
`include "npec_consts.svh"

module npec_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire npec_pkg::npec_byte_t page_byte,
	input wire logic page_start,
	input wire npec_pkg::npec_code_t stored_code,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	localparam int NSEC = `NPEC_SECTORS;
	localparam int LB = `NPEC_LOC_BITS;

	// Register select: 0 none, 1 ctrl, 2 stat lo, 3 stat hi, 16+n parity n
	function automatic logic [4:0] reg_sel(input logic [31:0] addr);
		logic [31:0] off;
		off = addr - `NPEC_PR0_ADDR;
		if (addr == `NPEC_CTRL_ADDR)
			reg_sel = 5'h01;
		else if (addr == `NPEC_STAT_LO_ADDR)
			reg_sel = 5'h02;
		else if (addr == `NPEC_STAT_HI_ADDR)
			reg_sel = 5'h03;
		else if (off[31:6] == 26'h0 && off[1:0] == 2'h0)
			reg_sel = {1'b1, off[5:2]}; // [R12] [R13]
		else
			reg_sel = 5'h00;
	endfunction

	// Running parity contribution of one byte: P xors the position of
	// every one bit, NP xors its complement, so one flipped bit moves
	// both halves in opposite directions.
	function automatic logic [2*LB-1:0] byte_parity(input logic [7:0] addr,
			input logic [7:0] data);
		logic [LB-1:0] p;
		logic [LB-1:0] np;
		logic [LB-1:0] pos;
		p = '0;
		np = '0;
		pos = '0;
		for (int b = 0; b < 8; b++) begin
			pos = {addr, 3'(b)};
			if (data[b]) begin
				p = p ^ pos;
				np = np ^ ~pos;
			end
		end
		byte_parity = {np, p};
	endfunction

	// Classify a stored code against the one rebuilt from the data
	function automatic npec_pkg::npec_verdict_t judge(input logic [2*LB-1:0] diff);
		if (diff == '0)
			judge = npec_pkg::NPEC_CLEAN;
		else if ((diff[LB-1:0] ^ diff[2*LB-1:LB]) == `NPEC_LOC_ALL_ONES)
			judge = npec_pkg::NPEC_DATA_ONE;
		else if ($onehot(diff))
			judge = npec_pkg::NPEC_CODE_ONE;
		else
			judge = npec_pkg::NPEC_MULTI;
	endfunction

	logic [11:0] byte_cnt_reg;
	logic [2*LB-1:0] acc_reg [NSEC];
	logic [`NPEC_CODE_BITS-1:0] par_reg [NSEC];
	npec_pkg::npec_flags_t flag_reg [NSEC];
	logic [31:0] ctrl_reg;
	logic granularity;
	logic aw_full_reg;
	logic w_full_reg;
	logic [31:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic [31:0] stat_lo;
	logic [31:0] stat_hi;
	logic [31:0] rd_word;
	logic [4:0] rsel;

	assign granularity = ctrl_reg[`NPEC_GRAN_BIT];

	// Page byte counter; sector index is the top nibble
	always_ff @(posedge aclk) begin
		if (!aresetn || page_start)
			byte_cnt_reg <= 12'h000;
		else if (page_byte.valid)
			byte_cnt_reg <= byte_cnt_reg + 12'h001; // [R11]
	end

	// Per-sector accumulators, parity registers and flags
	generate
		for (genvar s = 0; s < NSEC; s++) begin : g_sec
			logic hit;
			logic take_code;
			logic [2*LB-1:0] diff;
			npec_pkg::npec_verdict_t verdict;
			assign hit = page_byte.valid && byte_cnt_reg[11:8] == 4'(s);
			assign take_code = stored_code.valid && stored_code.sector == 4'(s);
			assign diff = {stored_code.code[`NPEC_NPAR_LSB +: LB],
				stored_code.code[`NPEC_LOC_LSB +: LB]} ^ acc_reg[s];
			assign verdict = judge(diff);

			// Parity grows with every byte of this sector
			always_ff @(posedge aclk) begin
				if (!aresetn || page_start)
					acc_reg[s] <= '0;
				else if (hit)
					acc_reg[s] <= acc_reg[s] ^ byte_parity(byte_cnt_reg[7:0],
						page_byte.data); // [R14]
			end

			// During a write the register tracks the code to store;
			// at comparison it takes the error location instead
			always_ff @(posedge aclk) begin
				if (!aresetn)
					par_reg[s] <= '0;
				else if (take_code) begin
					par_reg[s] <= '0;
					par_reg[s][`NPEC_NPAR_LSB +: LB] <= acc_reg[s][2*LB-1:LB]; // [R15]
					if (verdict == npec_pkg::NPEC_CODE_ONE)
						par_reg[s][`NPEC_LOC_LSB +: LB] <= diff[LB-1:0]; // [R5]
					else
						par_reg[s][`NPEC_LOC_LSB +: LB] <= diff[LB-1:0]; // [R7] [R8] [R9]
					if (verdict == npec_pkg::NPEC_CODE_ONE && diff[LB-1:0] == '0)
						par_reg[s][`NPEC_NPAR_LSB +: LB] <= diff[2*LB-1:LB]; // [R5]
				end else if (page_byte.write && hit) begin
					par_reg[s] <= '0;
					par_reg[s][`NPEC_LOC_LSB +: LB] <= acc_reg[s][LB-1:0] ^
						byte_parity(byte_cnt_reg[7:0], page_byte.data)
						[LB-1:0]; // [R14]
					par_reg[s][`NPEC_NPAR_LSB +: LB] <= acc_reg[s][2*LB-1:LB] ^
						byte_parity(byte_cnt_reg[7:0], page_byte.data)
						[2*LB-1:LB]; // [R15]
				end
			end

			// Flags only live while correction is enabled
			always_ff @(posedge aclk) begin
				if (!aresetn || !granularity)
					flag_reg[s] <= '0; // [R1]
				else if (take_code) begin
					flag_reg[s].rec <= verdict == npec_pkg::NPEC_DATA_ONE ||
						verdict == npec_pkg::NPEC_MULTI; // [R2] [R3]
					flag_reg[s].ecc <= verdict == npec_pkg::NPEC_CODE_ONE; // [R4]
					flag_reg[s].mul <= verdict == npec_pkg::NPEC_MULTI; // [R6]
				end
			end
		end
	endgenerate

	// Status words: four bits per sector, spare bit reads zero
	always_comb begin
		stat_lo = '0;
		stat_hi = '0;
		for (int s = 0; s < NSEC / 2; s++) begin
			stat_lo[4*s +: 3] = flag_reg[s];
			stat_hi[4*s +: 3] = flag_reg[s + NSEC / 2]; // [R11]
		end
	end

	// Write address and data are caught independently, in either order
	assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_full_reg && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			aw_full_reg <= 1'b0;
		else if (s_axi_awvalid && s_axi_awready)
			aw_full_reg <= 1'b1;
		else if (aw_full_reg && w_full_reg)
			aw_full_reg <= 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			w_full_reg <= 1'b0;
		else if (s_axi_wvalid && s_axi_wready)
			w_full_reg <= 1'b1;
		else if (aw_full_reg && w_full_reg)
			w_full_reg <= 1'b0;
	end

	// Payload holding registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr_reg <= '0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready)
				aw_addr_reg <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
		end
	end

	// Only the control word is writable; parity and status ignore writes
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctrl_reg <= `NPEC_CTRL_RESET;
		else if (aw_full_reg && w_full_reg && reg_sel(aw_addr_reg) == 5'h01
				&& w_strb_reg[0])
			ctrl_reg[0] <= w_data_reg[`NPEC_GRAN_BIT];
	end

	// Write response one edge after both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `NPEC_RESP_OKAY;
		end else if (aw_full_reg && w_full_reg) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= reg_sel(aw_addr_reg) == 5'h00 ?
				`NPEC_RESP_SLVERR : `NPEC_RESP_OKAY;
		end else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Read mux
	assign rsel = reg_sel(s_axi_araddr);
	always_comb begin
		case (rsel)
			5'h01: rd_word = ctrl_reg;
			5'h02: rd_word = stat_lo;
			5'h03: rd_word = stat_hi;
			default: rd_word = rsel[4] ? {8'h00, par_reg[rsel[3:0]]} : 32'h00000000;
		endcase
	end

	// One read in flight; new address taken only once the answer is gone
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `NPEC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rsel == 5'h00 ? `NPEC_RESP_SLVERR : `NPEC_RESP_OKAY;
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule

// file: testbench/npec_top_assertions.sv
// Checker for the register port of the page ECC block.
// Bound to npec_top; sees only its top-level ports.
`include "npec_consts.svh"

module npec_top_assertions (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic st_rd;
	logic pr_rd;
	logic rs;
	logic [31:0] d;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Short names keep each property on its label line
	assign d = s_axi_rdata;
	assign rs = s_axi_rvalid && st_rd;

	// Register family of the pending read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_rd <= 1'h0;
			pr_rd <= 1'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			st_rd <= (s_axi_araddr & ~32'h4) == `NPEC_STAT_LO_ADDR;
			pr_rd <= s_axi_araddr - `NPEC_PR0_ADDR < 32'h40;
		end
	end

	a_mul_rec: assert property (rs |-> ((d >> 2) & ~d & 32'h11111111) == 32'h0)
		else $error("multi flag without recoverable flag");
	a_ecc_rec: assert property (rs |-> ((d >> 1) & d & 32'h11111111) == 32'h0)
		else $error("code flag with recoverable flag");
	a_ecc_mul: assert property (rs |-> ((d >> 1) & (d >> 2) & 32'h11111111) == 32'h0)
		else $error("code flag with multi flag");
	a_flag_spare: assert property (rs |-> (d & 32'h88888888) == 32'h0)
		else $error("spare status bit set");
	a_parity_spare: assert property (s_axi_rvalid && pr_rd |-> d[31:23] == 9'h0 && !d[11])
		else $error("spare parity bit set");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(d))
		else $error("read data dropped before rready");
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> $stable(s_axi_bresp))
		else $error("write response changed before bready");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid)
		else $error("read answer late");
endmodule

bind npec_top npec_top_assertions npec_top_assertions_i (
	.aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready)
);

// file: testbench/npec_flash_model.sv
// Behavioural flash side: streams a page, then spare-area codes on a read.
// Assumes the bench fills mem, spare and use_code before calling send.
module npec_flash_model (
	input wire logic aclk,
	output npec_pkg::npec_byte_t page_byte,
	output logic page_start,
	output npec_pkg::npec_code_t stored_code
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [4096];
	logic [23:0] spare [16];
	logic [15:0] use_code;

	// Nothing valid from time zero
	initial begin
		page_byte = '0;
		page_start = 1'h0;
		stored_code = '0;
	end

	// One page; codes follow only on a read, after all data bytes
	task automatic send(input logic wr);
		@(posedge aclk);
		page_start <= 1'h1;
		@(posedge aclk);
		page_start <= 1'h0;
		for (int i = 0; i < 4096; i++) begin
			page_byte <= '{1'h1, wr, mem[i]};
			@(posedge aclk);
		end
		// Released lines must not echo the last byte
		page_byte <= '{1'h0, 1'h0, ~mem[4095]};
		for (int s = 0; s < 16; s++) begin
			if (!wr && use_code[s]) begin
				stored_code <= '{1'h1, 4'(s), spare[s]};
				@(posedge aclk);
			end
		end
		stored_code.valid <= 1'h0;
		@(posedge aclk);
	endtask
endmodule

// file: testbench/npec_top_tb.sv
// Bench for the page ECC block: AXI4-Lite tasks and a flash model.
// Assumes the constants header and package are compiled first.
`include "npec_consts.svh"

module npec_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, page_start;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [1:0] bresp, rresp;
	npec_pkg::npec_byte_t page_byte;
	npec_pkg::npec_code_t stored_code;
	int fail_count = 0;
	int n_checks = 0;

	npec_top npec_top_i (
		.aclk(aclk), .aresetn(aresetn), .page_byte(page_byte), .page_start(page_start),
		.stored_code(stored_code), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);
	npec_flash_model npec_flash_model_i (
		.aclk(aclk), .page_byte(page_byte), .page_start(page_start),
		.stored_code(stored_code)
	);

	// 50 MHz
	initial begin
		aclk = 1'h0;
		forever #10 aclk = ~aclk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Response ready stays up from the first request on, so the answer
	// is taken at the very edge where it is first seen
	task wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		chk(32'(bresp), 32'(er), "bresp");
	endtask

	task rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		chk(rdata, exp, $sformatf("rdata %h", a));
		chk(32'(rresp), 32'(er), "rresp");
	endtask

	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Three pages take about 12300 cycles
	initial begin
		#(20 * 40000);
		fail_count++;
		$display("ERROR watchdog expired");
		stop_test();
	end

	// Reset, write pass, read pass with faults, granularity off
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, wdata, araddr} = 96'h0;
		for (int i = 0; i < 4096; i++) npec_flash_model_i.mem[i] = 8'h00;
		npec_flash_model_i.use_code = 16'hA100;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rd(`NPEC_CTRL_ADDR, `NPEC_CTRL_RESET, `NPEC_RESP_OKAY);
		rd(`NPEC_PR8_ADDR, 32'h0, `NPEC_RESP_OKAY);
		rd(32'hFFFFE900, 32'h0, `NPEC_RESP_SLVERR);
		$display("test reset done");
		npec_flash_model_i.mem[12'h812] = 8'h20;
		npec_flash_model_i.send(1'h1);
		rd(`NPEC_PR8_ADDR, 32'h0076A095, `NPEC_RESP_OKAY);
		wr(`NPEC_PR8_ADDR, 32'hFFFFFFFF, `NPEC_RESP_OKAY);
		rd(`NPEC_PR8_ADDR, 32'h0076A095, `NPEC_RESP_OKAY);
		rd(`NPEC_PR13_ADDR, 32'h0, `NPEC_RESP_OKAY);
		wr(32'hFFFFE900, 32'h1, `NPEC_RESP_SLVERR);
		// Spare copies; sector 13 gets one bad code bit, sector 15 two
		npec_flash_model_i.spare[8] = 24'h76A095;
		npec_flash_model_i.spare[13] = 24'h000008;
		npec_flash_model_i.spare[15] = 24'h000003;
		$display("test write done");
		wr(`NPEC_CTRL_ADDR, 32'h1, `NPEC_RESP_OKAY);
		npec_flash_model_i.mem[12'h812] = 8'h24;
		npec_flash_model_i.send(1'h0);
		rd(`NPEC_STAT_HI_ADDR, 32'h50200001, `NPEC_RESP_OKAY);
		rd(`NPEC_STAT_LO_ADDR, 32'h0, `NPEC_RESP_OKAY);
		rd(`NPEC_PR8_ADDR, 32'h00007092, `NPEC_RESP_OKAY);
		rd(`NPEC_PR13_ADDR, 32'h00000008, `NPEC_RESP_OKAY);
		$display("test read done");
		wr(`NPEC_CTRL_ADDR, 32'h0, `NPEC_RESP_OKAY);
		rd(`NPEC_STAT_HI_ADDR, 32'h0, `NPEC_RESP_OKAY);
		npec_flash_model_i.send(1'h0);
		rd(`NPEC_STAT_HI_ADDR, 32'h0, `NPEC_RESP_OKAY);
		$display("test granularity done");
		stop_test();
	end
endmodule
